// File: hw/pmi_phy_end.sv
// Purpose: transceiver end of the controller-facing media interface
// Assumes: link pins sampled on mclk_i through three flops
// Notes: receive nibbles queue in a fifo drained at receive clock edges
`timescale 1ns/100ps
`include "pmi_defs.svh"
//
// Contract
// - mii transmit clock 25 or 2.5 MHz
// - transmit clock fixed phase to reference
// - rgmii transmit clock sourced by controller
// - transmit clock pin driven low in reset
// - controller enables data, four or two lines
// - transmit enable sampled at rising edge
// - rgmii control carries enable and error
// - enable on rise, error on fall
// - rgmii transmit clock 25 MHz at 100
// - mii nibble captured on rising edge
// - rmii leaves transmit clock pin unused
// - mii receive clock 25 MHz at 100
// - rgmii receive clock 25 MHz at 100
// - data valid marks receive data, four/two lines
// - rgmii receive control merges valid and status
module pmi_phy_end
    import pmi_pkg::*;
#(
    parameter int HALF_100 = `PMI_HALF100_CYC,
    parameter int HALF_10 = `PMI_HALF10_CYC,
    parameter int FIFO_DEPTH = `PMI_FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] mode_strap_i,
    input wire logic speed_100_i,
    input wire logic line_rx_valid_i,
    input wire logic [3:0] line_rx_data_i,
    input wire logic line_rx_err_i,
    output logic line_rx_ready_o,
    output logic line_tx_valid_o,
    output logic [3:0] line_tx_data_o,
    output logic line_tx_err_o,
    pmi_link_if.phy link
);
    localparam int CW = $clog2(HALF_10 + 1);

    pmi_mode_t mode_q;
    logic strap_done_q;
    logic spd_q;
    logic [CW-1:0] cnt_q;
    logic clk_q;
    logic tck_oe_q;
    logic tck_q;
    logic rck_q;
    logic refck_q;
    logic [5:0] s1_q;
    logic [5:0] s2_q;
    logic [5:0] s3_q;
    logic mck_f_q;
    logic mck_p_q;
    logic en_hold_q;
    logic [3:0] d_hold_q;
    logic half_q;
    logic [1:0] lo_q;
    logic tx_v_q;
    logic [3:0] tx_d_q;
    logic tx_e_q;
    pmi_rx_st_t st_q;
    logic [1:0] hi_q;
    logic er_q;
    logic rx_ctl_q;
    logic [3:0] rx_d_q;
    logic f_valid;
    logic [`PMI_FIFO_WIDTH-1:0] f_data;
    logic f_take_w;
    logic [CW-1:0] half_w;
    logic tick;
    logic rise_w;
    logic fall_w;
    logic mrise;
    logic mfall;
    logic is_mii;
    logic is_rmii;
    logic is_rgmii;
    logic cap_rise;
    logic clk_d;

    assign is_mii = (mode_q == PMI_MII);
    assign is_rmii = (mode_q == PMI_RMII);
    assign is_rgmii = (mode_q == PMI_RGMII);
    assign half_w = spd_q ? CW'(HALF_100) : CW'(HALF_10);
    assign tick = (cnt_q == half_w - 1'b1);
    assign rise_w = tick & ~clk_q;
    assign fall_w = tick & clk_q;
    assign clk_d = tick ? ~clk_q : clk_q;
    assign mrise = mck_f_q & ~mck_p_q;
    assign mfall = ~mck_f_q & mck_p_q;
    // rgmii edges come from the controller clock, else from our own
    assign cap_rise = is_rgmii ? mrise : rise_w;
    // pop only on the edges where the launch block below takes a word
    assign f_take_w = rise_w & strap_done_q & (st_q != PMI_RX_DIB_HI);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= pmi_mode_t'(`PMI_MODE_RST);
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            mode_q <= pmi_mode_t'(mode_strap_i);
            strap_done_q <= 1'b1;
        end
    end

    // tx and rx clocks share one divider, so phase stays fixed
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            spd_q <= 1'b0;
            cnt_q <= '0;
            clk_q <= 1'b0;
        end else begin
            spd_q <= speed_100_i;
            if (spd_q != speed_100_i || tick) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
            clk_q <= (spd_q != speed_100_i) ? 1'b0 : clk_d;
        end
    end

    // pin driven low as output while in reset
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tck_oe_q <= 1'b1;
            tck_q <= 1'b0;
            rck_q <= 1'b0;
            refck_q <= 1'b0;
        end else begin
            // pin released in rmii and, input in rgmii
            tck_oe_q <= ~strap_done_q | is_mii;
            tck_q <= strap_done_q & is_mii & clk_d;
            // receive clock toward controller, also in rgmii
            rck_q <= strap_done_q & ~is_rmii & clk_d;
            refck_q <= strap_done_q & is_rmii & clk_d;
        end
    end

    // link pins, three flops; clock change counts once stages 2 and 3 agree
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            mck_f_q <= 1'b0;
            mck_p_q <= 1'b0;
        end else begin
            s1_q <= {link.tx_clk, link.tx_ctl, link.tx_d};
            s2_q <= s1_q;
            s3_q <= s2_q;
            mck_f_q <= (s2_q[5] == s3_q[5]) ? s3_q[5] : mck_f_q;
            mck_p_q <= mck_f_q;
        end
    end

    // transmit capture toward the line
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_hold_q <= 1'b0;
            d_hold_q <= '0;
            half_q <= 1'b0;
            lo_q <= '0;
            tx_v_q <= 1'b0;
            tx_d_q <= '0;
            tx_e_q <= 1'b0;
        end else begin
            tx_v_q <= 1'b0;
            if (is_rgmii) begin
                if (cap_rise) begin
                    en_hold_q <= s3_q[4];
                    d_hold_q <= s3_q[3:0];
                end
                // error taken from the same line on fall
                if (mfall && en_hold_q) begin
                    tx_v_q <= 1'b1;
                    tx_d_q <= d_hold_q;
                    tx_e_q <= s3_q[4];
                end
            end else if (cap_rise) begin
                // enable qualifies data; nibble on rising edge
                if (!s3_q[4]) begin
                    half_q <= 1'b0;
                end else if (is_mii) begin
                    tx_v_q <= 1'b1;
                    tx_d_q <= s3_q[3:0];
                    tx_e_q <= 1'b0;
                end else if (!half_q) begin
                    lo_q <= s3_q[1:0];
                    half_q <= 1'b1;
                end else begin
                    tx_v_q <= 1'b1;
                    tx_d_q <= {s3_q[1:0], lo_q};
                    tx_e_q <= 1'b0;
                    half_q <= 1'b0;
                end
            end
        end
    end

    pmi_fifo #(
        .W(`PMI_FIFO_WIDTH),
        .D(FIFO_DEPTH)
    ) u_rx_fifo (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(line_rx_valid_i),
        .in_data_i({line_rx_err_i, line_rx_data_i}),
        .in_ready_o(line_rx_ready_o),
        .out_valid_o(f_valid),
        .out_data_o(f_data),
        .out_ready_i(f_take_w)
    );

    // receive launch toward the controller, on our own clock edges
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= PMI_RX_IDLE;
            hi_q <= '0;
            er_q <= 1'b0;
            rx_ctl_q <= 1'b0;
            rx_d_q <= '0;
        end else if (rise_w && strap_done_q) begin
            if (st_q == PMI_RX_DIB_HI) begin
                rx_d_q <= {2'b00, hi_q};
                st_q <= PMI_RX_NIB;
            end else if (f_valid) begin
                // valid with data, four or two lines
                rx_ctl_q <= 1'b1;
                er_q <= f_data[`PMI_ERR_BIT];
                hi_q <= f_data[3:2];
                rx_d_q <= is_rmii ? {2'b00, f_data[1:0]} : f_data[3:0];
                st_q <= is_rmii ? PMI_RX_DIB_HI : PMI_RX_NIB;
            end else begin
                rx_ctl_q <= 1'b0;
                rx_d_q <= '0;
                st_q <= PMI_RX_IDLE;
            end
        end else if (fall_w && is_rgmii) begin
            // same line carries status; error on fall
            rx_ctl_q <= (st_q != PMI_RX_IDLE) & er_q;
        end
    end

    assign link.tx_clk_p = tck_q;
    assign link.tx_clk_p_oe = tck_oe_q;
    assign link.rx_clk = rck_q;
    assign link.ref_clk = refck_q;
    assign link.rx_ctl = rx_ctl_q;
    assign link.rx_d = rx_d_q;
    assign line_tx_valid_o = tx_v_q;
    assign line_tx_data_o = tx_d_q;
    assign line_tx_err_o = tx_e_q;
endmodule : pmi_phy_end

// File: hw/pmi_defs.svh
// Purpose: shared timing and reset constants for the media interface
// Assumes: system clock of 20 MHz
// Notes: link clocks are emulated slower than real by a fixed scale
`ifndef PMI_DEFS_SVH
`define PMI_DEFS_SVH

`define PMI_MCLK_PERIOD_NS 50
`define PMI_CLK100_PERIOD_NS 40
`define PMI_CLK10_PERIOD_NS 400
// 20 MHz cannot toggle at 25 MHz; scale keeps the 10:1 speed ratio
`define PMI_LINK_SCALE 25
`define PMI_HALF100_CYC (`PMI_CLK100_PERIOD_NS * `PMI_LINK_SCALE / 2 / `PMI_MCLK_PERIOD_NS)
`define PMI_HALF10_CYC (`PMI_CLK10_PERIOD_NS * `PMI_LINK_SCALE / 2 / `PMI_MCLK_PERIOD_NS)
`define PMI_FIFO_DEPTH 8
`define PMI_FIFO_WIDTH 5
`define PMI_ERR_BIT 4
`define PMI_MODE_RST 2'h0

`endif

// File: hw/pmi_pkg.sv
// Purpose: types shared by both ends of the media interface
// Assumes: nothing
// Notes: mode codes match the strap encoding
package pmi_pkg;
    typedef enum logic [1:0] {
        PMI_MII = 2'b00,
        PMI_RMII = 2'b01,
        PMI_RGMII = 2'b10
    } pmi_mode_t;
    typedef enum logic [1:0] {
        PMI_RX_IDLE = 2'b00,
        PMI_RX_NIB = 2'b01,
        PMI_RX_DIB_HI = 2'b10
    } pmi_rx_st_t;
endpackage : pmi_pkg

// File: hw/pmi_link_if.sv
// Purpose: pins between the transceiver end and the controller end
// Assumes: both ends on one system clock
// Notes: the shared transmit clock pin is resolved here from the enables
`timescale 1ns/100ps
interface pmi_link_if;
    logic tx_clk_p;
    logic tx_clk_p_oe;
    logic tx_clk_m;
    logic tx_clk_m_oe;
    logic tx_clk;
    logic tx_ctl;
    logic [3:0] tx_d;
    logic rx_clk;
    logic ref_clk;
    logic rx_ctl;
    logic [3:0] rx_d;

    assign tx_clk = tx_clk_p_oe ? tx_clk_p : (tx_clk_m_oe ? tx_clk_m : 1'b0);

    modport phy (output tx_clk_p, output tx_clk_p_oe, input tx_clk, input tx_ctl,
                 input tx_d, output rx_clk, output ref_clk, output rx_ctl, output rx_d);
    modport mac (output tx_clk_m, output tx_clk_m_oe, input tx_clk, output tx_ctl,
                 output tx_d, input rx_clk, input ref_clk, input rx_ctl, input rx_d);
endinterface : pmi_link_if

// File: hw/pmi_fifo.sv
// Purpose: small synchronous fifo with valid and ready on both sides
// Assumes: single clock
// Notes: ready and valid come from registers
`timescale 1ns/100ps
module pmi_fifo #(
    parameter int W = 5,
    parameter int D = 8
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0] mem [D];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic wr;
    logic rd;

    assign wr = in_valid_i & in_ready_o;
    assign rd = out_valid_o & out_ready_i;
    assign cnt_d = cnt_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
    assign out_data_o = mem[rptr_q];

    always_ff @(posedge mclk_i) begin
        if (wr) begin
            mem[wptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
            in_ready_o <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            if (wr) begin
                wptr_q <= (wptr_q == AW'(D - 1)) ? '0 : wptr_q + 1'b1;
            end
            if (rd) begin
                rptr_q <= (rptr_q == AW'(D - 1)) ? '0 : rptr_q + 1'b1;
            end
            cnt_q <= cnt_d;
            in_ready_o <= (cnt_d != (AW + 1)'(D));
            out_valid_o <= (cnt_d != '0);
        end
    end
endmodule : pmi_fifo

// File: hw/pmi_mac_end.sv
// Purpose: controller end of the media interface
// Assumes: mode and speed set by controller logic on the same clock
// Notes: transmit clock is driven only in rgmii mode
`timescale 1ns/100ps
`include "pmi_defs.svh"
module pmi_mac_end
    import pmi_pkg::*;
#(
    parameter int HALF_100 = `PMI_HALF100_CYC,
    parameter int HALF_10 = `PMI_HALF10_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] mode_i,
    input wire logic speed_100_i,
    input wire logic user_tx_valid_i,
    input wire logic [3:0] user_tx_data_i,
    input wire logic user_tx_err_i,
    output logic user_tx_ready_o,
    output logic user_rx_valid_o,
    output logic [3:0] user_rx_data_o,
    output logic user_rx_err_o,
    pmi_link_if.mac link
);
    localparam int CW = $clog2(HALF_10 + 1);

    logic [CW-1:0] cnt_q;
    logic clk_q;
    logic spd_q;
    logic tck_q;
    logic tck_oe_q;
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [2:0] ck_f_q;
    logic [2:0] ck_p_q;
    logic [2:0] ck_rise;
    logic [2:0] ck_fall;
    logic tx_ctl_q;
    logic [3:0] tx_d_q;
    logic tx_hi_q;
    logic [1:0] tx_hold_q;
    logic er_hold_q;
    logic rdy_q;
    logic dv_hold_q;
    logic [3:0] rd_hold_q;
    logic rx_half_q;
    logic [1:0] rx_lo_q;
    logic rv_q;
    logic [3:0] rd_q;
    logic re_q;
    logic [CW-1:0] half_w;
    logic tick;
    logic is_rgmii;
    logic is_rmii;
    logic launch;
    logic own_fall;
    logic rx_rise;

    assign is_rgmii = (pmi_mode_t'(mode_i) == PMI_RGMII);
    assign is_rmii = (pmi_mode_t'(mode_i) == PMI_RMII);
    assign half_w = spd_q ? CW'(HALF_100) : CW'(HALF_10);
    assign tick = (cnt_q == half_w - 1'b1);
    assign own_fall = tick & clk_q;
    // bit 0 tx_clk, bit 1 ref_clk, bit 2 rx_clk
    assign launch = is_rgmii ? (tick & ~clk_q) : (is_rmii ? ck_rise[1] : ck_rise[0]);
    assign rx_rise = is_rmii ? ck_rise[1] : ck_rise[2];

    // own divider sources rgmii transmit clock; 25 MHz at 100
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            spd_q <= 1'b0;
            cnt_q <= '0;
            clk_q <= 1'b0;
            tck_q <= 1'b0;
            tck_oe_q <= 1'b0;
        end else begin
            spd_q <= speed_100_i;
            cnt_q <= (tick || spd_q != speed_100_i) ? '0 : cnt_q + 1'b1;
            clk_q <= (spd_q != speed_100_i) ? 1'b0 : clk_q ^ tick;
            tck_q <= is_rgmii & (clk_q ^ tick);
            tck_oe_q <= is_rgmii;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= {link.rx_clk, link.ref_clk, link.tx_clk, link.rx_ctl, link.rx_d};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // clock filters: change accepted once stages 2 and 3 agree
    for (genvar i = 0; i < 3; i++) begin : g_ckf
        always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                ck_f_q[i] <= 1'b0;
                ck_p_q[i] <= 1'b0;
            end else begin
                ck_f_q[i] <= (s2_q[5+i] == s3_q[5+i]) ? s3_q[5+i] : ck_f_q[i];
                ck_p_q[i] <= ck_f_q[i];
            end
        end
        assign ck_rise[i] = ck_f_q[i] & ~ck_p_q[i];
        assign ck_fall[i] = ~ck_f_q[i] & ck_p_q[i];
    end

    // transmit launch
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_ctl_q <= 1'b0;
            tx_d_q <= '0;
            tx_hi_q <= 1'b0;
            tx_hold_q <= '0;
            er_hold_q <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= 1'b0;
            if (launch) begin
                if (tx_hi_q) begin
                    tx_d_q <= {2'b00, tx_hold_q};
                    tx_hi_q <= 1'b0;
                end else if (user_tx_valid_i && !rdy_q) begin
                    // enable high with data; launched for rising edge
                    rdy_q <= 1'b1;
                    tx_ctl_q <= 1'b1;
                    er_hold_q <= user_tx_err_i & is_rgmii;
                    tx_hold_q <= user_tx_data_i[3:2];
                    tx_hi_q <= is_rmii;
                    tx_d_q <= is_rmii ? {2'b00, user_tx_data_i[1:0]} : user_tx_data_i;
                end else begin
                    tx_ctl_q <= 1'b0;
                    tx_d_q <= '0;
                end
            end else if (own_fall && is_rgmii) begin
                // error placed for the falling edge
                tx_ctl_q <= tx_ctl_q & er_hold_q;
            end
        end
    end

    // receive capture
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dv_hold_q <= 1'b0;
            rd_hold_q <= '0;
            rx_half_q <= 1'b0;
            rx_lo_q <= '0;
            rv_q <= 1'b0;
            rd_q <= '0;
            re_q <= 1'b0;
        end else begin
            rv_q <= 1'b0;
            if (is_rgmii) begin
                if (rx_rise) begin
                    dv_hold_q <= s3_q[4];
                    rd_hold_q <= s3_q[3:0];
                end
                if (ck_fall[2] && dv_hold_q) begin
                    rv_q <= 1'b1;
                    rd_q <= rd_hold_q;
                    re_q <= s3_q[4];
                end
            end else if (rx_rise) begin
                if (!s3_q[4]) begin
                    rx_half_q <= 1'b0;
                end else if (!is_rmii) begin
                    rv_q <= 1'b1;
                    rd_q <= s3_q[3:0];
                    re_q <= 1'b0;
                end else if (!rx_half_q) begin
                    rx_lo_q <= s3_q[1:0];
                    rx_half_q <= 1'b1;
                end else begin
                    rv_q <= 1'b1;
                    rd_q <= {s3_q[1:0], rx_lo_q};
                    re_q <= 1'b0;
                    rx_half_q <= 1'b0;
                end
            end
        end
    end

    assign link.tx_clk_m = tck_q;
    assign link.tx_clk_m_oe = tck_oe_q;
    assign link.tx_ctl = tx_ctl_q;
    assign link.tx_d = tx_d_q;
    assign user_tx_ready_o = rdy_q;
    assign user_rx_valid_o = rv_q;
    assign user_rx_data_o = rd_q;
    assign user_rx_err_o = re_q;
endmodule : pmi_mac_end

// File: verif/pmi_link_properties.sv
// Purpose: pin-level properties of the link between both ends
// Assumes: both ends on mclk_i, half periods in system cycles
// Notes: mode is not visible here, so checks hold in every mode
`timescale 1ns/100ps
module pmi_link_properties #(
    parameter int HALF_10 = 20
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic tx_clk_p,
    input wire logic tx_clk_p_oe,
    input wire logic tx_clk_m,
    input wire logic tx_clk_m_oe,
    input wire logic tx_clk,
    input wire logic tx_ctl,
    input wire logic [3:0] tx_d,
    input wire logic rx_clk,
    input wire logic ref_clk,
    input wire logic rx_ctl,
    input wire logic [3:0] rx_d
);
    localparam int MAXP = 2 * HALF_10;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    // reset values only exist once the first edge has applied them
    logic armed_q = 1'b0;
    always @(posedge mclk_i) armed_q <= 1'b1;

    reset_pin_low_a: assert property (disable iff (1'b0)
        armed_q && !rst_n_i |-> tx_clk_p_oe && !tx_clk_p)
        else $error("tx clock pin not low in reset");
    no_contention_a: assert property (
        tx_clk_m_oe && tx_clk_m |-> !tx_clk_p_oe) else $error("both ends drive tx clock");
    rx_clk_high_a: assert property (
        $rose(rx_clk) |=> rx_clk [*8]) else $error("rx clock high half too short");
    rx_clk_fall_a: assert property (
        $rose(rx_clk) |-> ##[1:MAXP] $fell(rx_clk)) else $error("rx clock high half too long");
    rx_data_hold_a: assert property (
        !$rose(rx_clk) && !$rose(ref_clk) |-> $stable(rx_d)) else $error("rx data moved off edge");
    rx_ctl_hold_a: assert property (
        !$changed(rx_clk) && !$rose(ref_clk) |-> $stable(rx_ctl))
        else $error("rx control moved off edge");
    one_rx_clock_a: assert property (
        !(rx_clk && ref_clk)) else $error("rx and reference clocks both high");
    tx_clk_high_a: assert property (
        $rose(tx_clk) |=> tx_clk [*8]) else $error("tx clock high half too short");
    tx_data_hold_a: assert property (
        $changed(tx_d) |=> $stable(tx_d) [*8]) else $error("tx data not held");

    cover property ($rose(rx_clk) && rx_ctl);
    cover property (tx_clk_m_oe && tx_ctl);
    cover property ($rose(ref_clk) && rx_ctl);
endmodule : pmi_link_properties

// File: verif/testbench.sv
// Purpose: drives both ends back to back through every mode
// Assumes: half periods of 10 and 20 system cycles, the slow one shortened from 100
// Notes: mode strap is caught at reset, so each scenario resets
`timescale 1ns/100ps
module testbench;
    import pmi_pkg::*;
    localparam int H100 = 10;
    localparam int H10 = 20;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [1:0] mode = PMI_MII;
    logic speed = 1'b1;
    logic lrx_v = 1'b0;
    logic [3:0] lrx_d = 4'h0;
    logic lrx_e = 1'b0;
    logic utx_v = 1'b0;
    logic [3:0] utx_d = 4'h0;
    logic utx_e = 1'b0;
    logic lrx_rdy, ltx_v, ltx_e, utx_rdy, urx_v, urx_e;
    logic [3:0] ltx_d, urx_d;
    logic [4:0] txq[$];
    logic [4:0] rxq[$];
    logic [4:0] expq[$];
    logic saw_full = 1'b0;
    int mismatches = 0;
    int samples_checked = 0;

    pmi_link_if link ();
    pmi_phy_end #(.HALF_100(H100), .HALF_10(H10), .FIFO_DEPTH(8)) pmi_phy_end_inst (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .mode_strap_i(mode), .speed_100_i(speed),
        .line_rx_valid_i(lrx_v), .line_rx_data_i(lrx_d), .line_rx_err_i(lrx_e),
        .line_rx_ready_o(lrx_rdy), .line_tx_valid_o(ltx_v), .line_tx_data_o(ltx_d),
        .line_tx_err_o(ltx_e), .link(link));
    pmi_mac_end #(.HALF_100(H100), .HALF_10(H10)) pmi_mac_end_inst (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .mode_i(mode), .speed_100_i(speed),
        .user_tx_valid_i(utx_v), .user_tx_data_i(utx_d), .user_tx_err_i(utx_e),
        .user_tx_ready_o(utx_rdy), .user_rx_valid_o(urx_v), .user_rx_data_o(urx_d),
        .user_rx_err_o(urx_e), .link(link));
    pmi_link_properties #(.HALF_10(H10)) pmi_link_properties_inst (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .tx_clk_p(link.tx_clk_p),
        .tx_clk_p_oe(link.tx_clk_p_oe), .tx_clk_m(link.tx_clk_m),
        .tx_clk_m_oe(link.tx_clk_m_oe), .tx_clk(link.tx_clk), .tx_ctl(link.tx_ctl),
        .tx_d(link.tx_d), .rx_clk(link.rx_clk), .ref_clk(link.ref_clk),
        .rx_ctl(link.rx_ctl), .rx_d(link.rx_d));

    always #25 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        if (ltx_v === 1'b1) txq.push_back({ltx_e, ltx_d});
        if (urx_v === 1'b1) rxq.push_back({urx_e, urx_d});
    end
    always @(negedge mclk_i) if (lrx_v && lrx_rdy === 1'b0) saw_full = 1'b1;

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic report_and_stop;
        if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task automatic reset_to(input pmi_mode_t m, input logic s);
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        mode <= m;
        speed <= s;
        repeat (12) @(posedge mclk_i);
        chk("tx_clk_reset", 8'h0, {7'h0, link.tx_clk});
        chk("tx_oe_reset", 8'h1, {7'h0, link.tx_clk_p_oe});
        rst_n_i <= 1'b1;
        repeat (4) @(negedge mclk_i);
        chk("tx_oe_after", {7'h0, (m == PMI_MII)}, {7'h0, link.tx_clk_p_oe});
    endtask : reset_to

    task automatic line_push(input logic [4:0] w);
        logic r;
        lrx_v <= 1'b1;
        lrx_d <= w[3:0];
        lrx_e <= w[4];
        do begin
            @(negedge mclk_i);
            r = lrx_rdy;
            @(posedge mclk_i);
        end while (r !== 1'b1);
    endtask : line_push

    task automatic user_push(input logic [4:0] w);
        logic r;
        utx_v <= 1'b1;
        utx_d <= w[3:0];
        utx_e <= w[4];
        do begin
            @(negedge mclk_i);
            r = utx_rdy;
            @(posedge mclk_i);
        end while (r !== 1'b1);
    endtask : user_push

    // ten back to back words fill the eight-word fifo
    task automatic t_rx(input pmi_mode_t m);
        reset_to(m, 1'b1);
        saw_full = 1'b0;
        rxq.delete();
        expq.delete();
        @(posedge mclk_i);
        for (int i = 0; i < 10; i++) begin
            expq.push_back({i[0] & (m == PMI_RGMII), 4'(i * 5 + 3)});
            line_push(expq[i]);
        end
        lrx_v <= 1'b0;
        while (rxq.size() < 10) @(posedge mclk_i);
        chk("rx_full_seen", 8'h1, {7'h0, saw_full});
        foreach (expq[i]) chk("rx_word", {3'h0, expq[i]}, {3'h0, rxq[i]});
    endtask : t_rx

    task automatic t_tx(input pmi_mode_t m);
        reset_to(m, 1'b1);
        txq.delete();
        expq.delete();
        @(posedge mclk_i);
        for (int i = 0; i < 6; i++) begin
            expq.push_back({i[0] & (m == PMI_RGMII), 4'(15 - i * 3)});
            user_push(expq[i]);
        end
        utx_v <= 1'b0;
        while (txq.size() < 6) @(posedge mclk_i);
        foreach (expq[i]) chk("tx_word", {3'h0, expq[i]}, {3'h0, txq[i]});
    endtask : t_tx

    task automatic t_clk(input pmi_mode_t m, input logic s, input int half);
        time t0;
        reset_to(m, s);
        @(posedge link.tx_clk);
        repeat (2) begin
            t0 = $time;
            @(posedge link.tx_clk);
            chk("tx_clk_period", 8'(2 * half), 8'(($time - t0) / 50));
        end
        // both phy clocks come from one divider
        @(negedge mclk_i);
        if (m == PMI_MII) chk("tx_rx_phase", {7'h0, link.rx_clk}, {7'h0, link.tx_clk});
    endtask : t_clk

    task automatic t_rmii_clk;
        logic seen;
        reset_to(PMI_RMII, 1'b1);
        seen = 1'b0;
        repeat (80) begin
            @(posedge mclk_i);
            seen = seen | link.tx_clk;
        end
        chk("tx_clk_rmii", 8'h0, {7'h0, seen});
    endtask : t_rmii_clk

    initial begin
        t_rx(PMI_MII);
        t_rx(PMI_RMII);
        t_rx(PMI_RGMII);
        t_tx(PMI_MII);
        t_tx(PMI_RMII);
        t_tx(PMI_RGMII);
        t_clk(PMI_MII, 1'b1, H100);
        t_clk(PMI_MII, 1'b0, H10);
        t_clk(PMI_RGMII, 1'b1, H100);
        t_clk(PMI_RGMII, 1'b0, H10);
        t_rmii_clk();
        report_and_stop();
    end

    // budget is several times the expected run
    initial begin
        repeat (20000) @(posedge mclk_i);
        mismatches++;
        report_and_stop();
    end
endmodule : testbench
